// >>> rtl/asp_pkg.sv
// Constants, register map and carrier types of the audio sample ports.
// Assumes a single 50 MHz system clock that also stands for the crystal clock.
package asp_pkg;
   localparam logic [15:0] ASP_ADDR_I2S_SETUP = 16'hC040;
   localparam logic [15:0] ASP_ADDR_ADC_CTRL = 16'hC042;
   localparam logic [15:0] ASP_ADDR_ADC_LEFT = 16'hC043;
   localparam logic [15:0] ASP_ADDR_ADC_RIGHT = 16'hC044;
   localparam logic [15:0] ASP_ADDR_RSMP_CTRL = 16'hC046;
   localparam logic [15:0] ASP_ADDR_RSMP_LEFT = 16'hC047;
   localparam logic [15:0] ASP_ADDR_RSMP_RIGHT = 16'hC048;
   localparam logic [15:0] ASP_ADDR_SIDE_CTRL = 16'hC049;
   localparam logic [15:0] ASP_ADDR_SIDE_LEFT = 16'hC04A;
   localparam logic [15:0] ASP_ADDR_SIDE_RIGHT = 16'hC04B;
   localparam int ASP_SETUP_RATE_LSB = 0;
   localparam int ASP_SETUP_ENABLE_BIT = 2;
   localparam int ASP_SETUP_MCLK_BIT = 3;
   localparam int ASP_ADC_ENABLE_BIT = 0;
   localparam int ASP_ADC_DECIM_LSB = 1;
   localparam int ASP_ADC_LEFT_PD_BIT = 3;
   localparam int ASP_ADC_RIGHT_PD_BIT = 4;
   localparam int ASP_DIV_ENABLE_BIT = 12;
   localparam logic [3:0] ASP_SETUP_RESET = 4'h0;
   localparam logic [4:0] ASP_ADC_CTRL_RESET = 5'h00;
   localparam logic [12:0] ASP_DIV_CTRL_RESET = 13'h0000;
   localparam logic [15:0] ASP_SAMPLE_RESET = 16'h0000;
   localparam logic [1:0] ASP_RATE_48K = 2'h0;
   localparam logic [1:0] ASP_RATE_96K = 2'h1;
   localparam logic [1:0] ASP_RATE_192K = 2'h2;
   // Bit clock half periods in master clock toggles, so it divides by 8, 4, 2
   localparam logic [3:0] ASP_SCLK_HALF_48K = 4'h8;
   localparam logic [3:0] ASP_SCLK_HALF_96K = 4'h4;
   localparam logic [3:0] ASP_SCLK_HALF_192K = 4'h2;
   // ADC decimation periods in crystal cycles, doubled in half-speed mode
   localparam logic [10:0] ASP_DECIM_64 = 11'h040;
   localparam logic [10:0] ASP_DECIM_128 = 11'h080;
   localparam logic [10:0] ASP_DECIM_256 = 11'h100;
   localparam logic [10:0] ASP_DECIM_512 = 11'h200;
   localparam int ASP_SLOT_BITS = 32;
   localparam int ASP_DATA_W = 16;

   typedef struct packed {
      logic [15:0] left;
      logic [15:0] right;
   } asp_pair_s;

   typedef struct packed {
      logic write;
      logic read;
      logic [15:0] addr;
      logic [15:0] wdata;
   } asp_bus_s;
endpackage

// >>> rtl/asp_rate_gen.sv
// Programmable sample-rate tick: one pulse every 2*(div+1) clocks while on.
// Assumes div and on come from registers in the same clock domain.
`timescale 1ns/100ps
module asp_rate_gen
   import asp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic on,
   input wire logic [11:0] div,
   output logic tick
);
   logic [12:0] count;
   logic [12:0] next_count;
   logic next_tick;
   logic [12:0] period_last;

   always_comb
   begin
      period_last = {div, 1'b1};
      next_count = count;
      next_tick = 1'b0;
      if (!on)
      begin
         next_count = 13'h0000;
      end
      else if (count >= period_last)
      begin
         next_count = 13'h0000;
         next_tick = 1'b1;
      end
      else
      begin
         next_count = count + 13'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= 13'h0000;
         tick <= 1'b0;
      end
      else
      begin
         count <= next_count;
         tick <= next_tick;
      end
   end
endmodule

// >>> rtl/asp_top.sv
// Audio sample ports: serial audio output, ADC decimator front, resampler tap
// and sidestream injector, all behind the processor's memory-mapped registers.
// Assumes a single-cycle register bus with read data registered one cycle later,
// and that the crystal clock drives clk_sys.
`timescale 1ns/100ps
module asp_top
   import asp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire asp_bus_s bus,
   output logic [15:0] bus_rdata,
   input wire logic high_input_clock_range,
   input wire logic adc_half_speed,
   input wire asp_pair_s dac_path,
   input wire asp_pair_s adc_raw,
   output asp_pair_s dac_mixed,
   output logic master_clock_out,
   output logic bit_clock_out,
   output logic frame_clock_out,
   output logic serial_data_out,
   output logic port_pins_active,
   output logic adc_left_run,
   output logic adc_right_run,
   output logic adc_irq,
   output logic resampler_irq,
   output logic sidestream_irq
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [3:0] i2s_setup;
   logic [4:0] adc_ctrl;
   logic [12:0] resampler_ctrl;
   logic [12:0] sidestream_ctrl;
   asp_pair_s adc_sample;
   asp_pair_s resampler_sample;
   asp_pair_s sidestream_sample;
   logic [3:0] next_i2s_setup;
   logic [4:0] next_adc_ctrl;
   logic [12:0] next_resampler_ctrl;
   logic [12:0] next_sidestream_ctrl;
   asp_pair_s next_adc_sample;
   asp_pair_s next_resampler_sample;
   asp_pair_s next_sidestream_sample;
   logic [15:0] next_bus_rdata;

   logic port_enable;
   logic master_clock_out_enable;
   logic [1:0] port_rate_select;
   logic resampler_on;
   logic sidestream_on;
   logic [11:0] resampler_divider;
   logic [11:0] sidestream_divider;
   logic adc_tick;
   logic resampler_tick;
   logic sidestream_tick;

   assign port_enable = i2s_setup[ASP_SETUP_ENABLE_BIT];
   assign master_clock_out_enable = i2s_setup[ASP_SETUP_MCLK_BIT];
   assign port_rate_select = i2s_setup[ASP_SETUP_RATE_LSB +: 2];
   assign resampler_on = resampler_ctrl[ASP_DIV_ENABLE_BIT];
   assign sidestream_on = sidestream_ctrl[ASP_DIV_ENABLE_BIT];
   assign resampler_divider = resampler_ctrl[11:0];
   assign sidestream_divider = sidestream_ctrl[11:0];

   function automatic logic [15:0] read_mux(input logic [15:0] a);
      logic [15:0] r;
      r = 16'h0000;
      if (a == ASP_ADDR_I2S_SETUP)
         r = {12'h000, i2s_setup};
      else if (a == ASP_ADDR_ADC_CTRL)
         r = {11'h000, adc_ctrl};
      else if (a == ASP_ADDR_ADC_LEFT)
         r = adc_sample.left;
      else if (a == ASP_ADDR_ADC_RIGHT)
         r = adc_sample.right;
      else if (a == ASP_ADDR_RSMP_CTRL)
         r = {3'h0, resampler_ctrl};
      else if (a == ASP_ADDR_RSMP_LEFT)
         r = resampler_sample.left;
      else if (a == ASP_ADDR_RSMP_RIGHT)
         r = resampler_sample.right;
      else if (a == ASP_ADDR_SIDE_CTRL)
         r = {3'h0, sidestream_ctrl};
      else if (a == ASP_ADDR_SIDE_LEFT)
         r = sidestream_sample.left;
      else if (a == ASP_ADDR_SIDE_RIGHT)
         r = sidestream_sample.right;
      return r;
   endfunction

   always_comb
   begin
      next_i2s_setup = i2s_setup;
      next_adc_ctrl = adc_ctrl;
      next_resampler_ctrl = resampler_ctrl;
      next_sidestream_ctrl = sidestream_ctrl;
      next_sidestream_sample = sidestream_sample;
      next_bus_rdata = bus.read ? read_mux(bus.addr) : 16'h0000;
      if (bus.write)
      begin
         if (bus.addr == ASP_ADDR_I2S_SETUP)
         begin
            next_i2s_setup = bus.wdata[3:0];
            // Rate is frozen while the port runs; a live rate change would
            // tear the frame in mid-slot.
            if (port_enable)
               next_i2s_setup[ASP_SETUP_RATE_LSB +: 2] = port_rate_select;
         end
         else if (bus.addr == ASP_ADDR_ADC_CTRL)
            next_adc_ctrl = bus.wdata[4:0];
         else if (bus.addr == ASP_ADDR_RSMP_CTRL)
            next_resampler_ctrl = bus.wdata[12:0];
         else if (bus.addr == ASP_ADDR_SIDE_CTRL)
            next_sidestream_ctrl = bus.wdata[12:0];
         else if (bus.addr == ASP_ADDR_SIDE_LEFT)
            next_sidestream_sample.left = bus.wdata;
         else if (bus.addr == ASP_ADDR_SIDE_RIGHT)
            next_sidestream_sample.right = bus.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         i2s_setup <= ASP_SETUP_RESET;
         adc_ctrl <= ASP_ADC_CTRL_RESET;
         resampler_ctrl <= ASP_DIV_CTRL_RESET;
         sidestream_ctrl <= ASP_DIV_CTRL_RESET;
         sidestream_sample <= {ASP_SAMPLE_RESET, ASP_SAMPLE_RESET};
         bus_rdata <= 16'h0000;
      end
      else
      begin
         i2s_setup <= next_i2s_setup;
         adc_ctrl <= next_adc_ctrl;
         resampler_ctrl <= next_resampler_ctrl;
         sidestream_ctrl <= next_sidestream_ctrl;
         sidestream_sample <= next_sidestream_sample;
         bus_rdata <= next_bus_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Master clock and serial audio port
   // ---------------------------------------------------------------
   // The master clock toggles on its own enable; in normal range it follows
   // the input rate as a tick per cycle, in high range every other cycle.
   logic mclk_phase;
   logic next_mclk_phase;
   logic mclk_tick;
   logic next_master_clock_out;
   logic [3:0] sclk_count;
   logic [3:0] next_sclk_count;
   logic [3:0] sclk_half;
   logic [5:0] slot_bit;
   logic [5:0] next_slot_bit;
   logic [31:0] shift;
   logic [31:0] next_shift;
   logic next_bit_clock_out;
   logic next_frame_clock_out;
   logic next_serial_data_out;
   logic next_port_pins_active;

   assign mclk_tick = high_input_clock_range ? mclk_phase : 1'b1;

   always_comb
   begin
      case (port_rate_select)
         ASP_RATE_96K: sclk_half = ASP_SCLK_HALF_96K;
         ASP_RATE_192K: sclk_half = ASP_SCLK_HALF_192K;
         default: sclk_half = ASP_SCLK_HALF_48K;
      endcase
      next_mclk_phase = ~mclk_phase;
      next_master_clock_out = master_clock_out & master_clock_out_enable;
      if (master_clock_out_enable && mclk_tick)
         next_master_clock_out = clk_phase_src();
      next_port_pins_active = port_enable;
      next_sclk_count = sclk_count;
      next_bit_clock_out = bit_clock_out;
      next_frame_clock_out = frame_clock_out;
      next_serial_data_out = serial_data_out;
      next_slot_bit = slot_bit;
      next_shift = shift;
      if (!port_enable)
      begin
         next_sclk_count = 4'h0;
         next_bit_clock_out = 1'b0;
         next_frame_clock_out = 1'b0;
         next_serial_data_out = 1'b0;
         next_slot_bit = 6'h00;
      end
      else if (mclk_tick)
      begin
         if (sclk_count + 4'h1 >= sclk_half)
         begin
            next_sclk_count = 4'h0;
            next_bit_clock_out = ~bit_clock_out;
            // Data and word select change on the falling bit clock edge
            if (bit_clock_out)
            begin
               next_slot_bit = (slot_bit == 6'(2 * ASP_SLOT_BITS - 1)) ? 6'h00 : slot_bit + 6'h01;
               next_frame_clock_out = next_slot_bit[5];
               if (next_slot_bit[4:0] == 5'h00)
                  // Audio comes from the DAC path after the sidestream mix (dac_mixed), not the source file rate
                  next_shift = {next_slot_bit[5] ? dac_mixed.right : dac_mixed.left,
                                16'h0000};
               else
                  next_shift = {shift[30:0], 1'b0};
               next_serial_data_out = next_shift[31];
            end
         end
         else
            next_sclk_count = sclk_count + 4'h1;
      end
   end

   // Full-rate master clock cannot be a flip-flop toggle at one edge per
   // cycle, so it alternates each cycle; the pin rate is then clk/2 at best.
   function automatic logic clk_phase_src();
      return ~master_clock_out;
   endfunction

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mclk_phase <= 1'b0;
         master_clock_out <= 1'b0;
         sclk_count <= 4'h0;
         bit_clock_out <= 1'b0;
         frame_clock_out <= 1'b0;
         serial_data_out <= 1'b0;
         slot_bit <= 6'h00;
         shift <= 32'h0000_0000;
         port_pins_active <= 1'b0;
      end
      else
      begin
         mclk_phase <= next_mclk_phase;
         master_clock_out <= next_master_clock_out;
         sclk_count <= next_sclk_count;
         bit_clock_out <= next_bit_clock_out;
         frame_clock_out <= next_frame_clock_out;
         serial_data_out <= next_serial_data_out;
         slot_bit <= next_slot_bit;
         shift <= next_shift;
         port_pins_active <= next_port_pins_active;
      end
   end

   // ---------------------------------------------------------------
   // ADC decimator
   // ---------------------------------------------------------------
   logic [11:0] decim_count;
   logic [11:0] next_decim_count;
   logic [11:0] decim_period;
   logic next_adc_tick;
   logic next_adc_left_run;
   logic next_adc_right_run;

   always_comb
   begin
      case (adc_ctrl[ASP_ADC_DECIM_LSB +: 2])
         2'h3: decim_period = {1'b0, ASP_DECIM_512};
         2'h2: decim_period = {1'b0, ASP_DECIM_256};
         2'h1: decim_period = {1'b0, ASP_DECIM_128};
         default: decim_period = {1'b0, ASP_DECIM_64};
      endcase
      if (adc_half_speed)
         decim_period = {decim_period[10:0], 1'b0};
      next_adc_tick = 1'b0;
      next_decim_count = decim_count + 12'h001;
      if (!adc_ctrl[ASP_ADC_ENABLE_BIT])
         next_decim_count = 12'h000;
      else if (decim_count >= decim_period - 12'h001)
      begin
         next_decim_count = 12'h000;
         next_adc_tick = 1'b1;
      end
      next_adc_left_run = adc_ctrl[ASP_ADC_ENABLE_BIT] & ~adc_ctrl[ASP_ADC_LEFT_PD_BIT];
      next_adc_right_run = adc_ctrl[ASP_ADC_ENABLE_BIT] & ~adc_ctrl[ASP_ADC_RIGHT_PD_BIT];
      next_adc_sample = adc_sample;
      if (next_adc_tick)
      begin
         next_adc_sample.left = next_adc_left_run ? adc_raw.left : 16'h0000;
         next_adc_sample.right = next_adc_right_run ? adc_raw.right : 16'h0000;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         decim_count <= 12'h000;
         adc_tick <= 1'b0;
         adc_left_run <= 1'b0;
         adc_right_run <= 1'b0;
         adc_sample <= {ASP_SAMPLE_RESET, ASP_SAMPLE_RESET};
      end
      else
      begin
         decim_count <= next_decim_count;
         adc_tick <= next_adc_tick;
         adc_left_run <= next_adc_left_run;
         adc_right_run <= next_adc_right_run;
         adc_sample <= next_adc_sample;
      end
   end

   // ---------------------------------------------------------------
   // Resampler tap and sidestream injector
   // ---------------------------------------------------------------
   asp_rate_gen u_resampler_rate
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .on(resampler_on),
      .div(resampler_divider),
      .tick(resampler_tick)
   );

   asp_rate_gen u_sidestream_rate
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .on(sidestream_on),
      .div(sidestream_divider),
      .tick(sidestream_tick)
   );

   asp_pair_s next_dac_mixed;

   always_comb
   begin
      next_resampler_sample = resampler_sample;
      // Plain sample-and-hold; low rates alias by design
      if (resampler_tick)
         next_resampler_sample = dac_path;
      next_dac_mixed = dac_path;
      // Direct sum, no filtering, wraps on overflow
      if (sidestream_on)
      begin
         next_dac_mixed.left = dac_path.left + sidestream_sample.left;
         next_dac_mixed.right = dac_path.right + sidestream_sample.right;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resampler_sample <= {ASP_SAMPLE_RESET, ASP_SAMPLE_RESET};
         dac_mixed <= {ASP_SAMPLE_RESET, ASP_SAMPLE_RESET};
         adc_irq <= 1'b0;
         resampler_irq <= 1'b0;
         sidestream_irq <= 1'b0;
      end
      else
      begin
         resampler_sample <= next_resampler_sample;
         dac_mixed <= next_dac_mixed;
         adc_irq <= adc_tick;
         resampler_irq <= resampler_tick;
         sidestream_irq <= sidestream_tick;
      end
   end
endmodule

// >>> sim/asp_top_assertions.sv
// Concurrent checks on the asp_top ports.
// Assumes the bus and pulse timing of the hand-over; bound at the foot.
`timescale 1ns/100ps
module asp_top_checker
   import asp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire asp_bus_s bus,
   input wire logic high_input_clock_range,
   input wire logic master_clock_out,
   input wire logic bit_clock_out,
   input wire logic frame_clock_out,
   input wire logic serial_data_out,
   input wire logic port_pins_active,
   input wire logic adc_left_run,
   input wire logic adc_right_run,
   input wire logic adc_irq,
   input wire logic resampler_irq,
   input wire logic sidestream_irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic [11:0] rs_div, sd_div;
   logic [13:0] rs_cnt, sd_cnt;
   logic rs_ok, sd_ok, wr_rs, wr_sd;
   assign wr_rs = bus.write && bus.addr == ASP_ADDR_RSMP_CTRL;
   assign wr_sd = bus.write && bus.addr == ASP_ADDR_SIDE_CTRL;
   // A rewrite may restart a divider, so spacing is judged from the next pulse on
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         {rs_div, sd_div, rs_cnt, sd_cnt, rs_ok, sd_ok} <= '0;
      else
      begin
         rs_cnt <= resampler_irq ? 14'h0001 : rs_cnt + 14'h0001;
         sd_cnt <= sidestream_irq ? 14'h0001 : sd_cnt + 14'h0001;
         rs_ok <= !wr_rs && (resampler_irq || rs_ok);
         sd_ok <= !wr_sd && (sidestream_irq || sd_ok);
         if (wr_rs)
            rs_div <= bus.wdata[11:0];
         if (wr_sd)
            sd_div <= bus.wdata[11:0];
      end
   end
   sequence s_setup_wr;
      bus.write && bus.addr == ASP_ADDR_I2S_SETUP;
   endsequence
   sequence s_adc_wr;
      bus.write && bus.addr == ASP_ADDR_ADC_CTRL;
   endsequence
   property p_port_on;
      s_setup_wr ##0 bus.wdata[ASP_SETUP_ENABLE_BIT] |-> ##[1:2] port_pins_active;
   endproperty
   property p_pins_idle;
      !port_pins_active && $past(!port_pins_active)
         |-> !(bit_clock_out || frame_clock_out || serial_data_out);
   endproperty
   property p_mclk_off;
      s_setup_wr ##0 !bus.wdata[ASP_SETUP_MCLK_BIT] |-> ##2 !master_clock_out;
   endproperty
   property p_mclk_norm;
      !high_input_clock_range && master_clock_out |=> !master_clock_out;
   endproperty
   property p_mclk_high;
      high_input_clock_range && $rose(master_clock_out) && !bus.write && !$past(bus.write)
         && !$past(bus.write, 2) |=> master_clock_out ##1 !master_clock_out;
   endproperty
   property p_rs_period;
      resampler_irq && rs_ok |-> rs_cnt == (14'(rs_div) + 14'h0001) << 1;
   endproperty
   property p_sd_period;
      sidestream_irq && sd_ok |-> sd_cnt == (14'(sd_div) + 14'h0001) << 1;
   endproperty
   property p_irq_single;
      adc_irq || resampler_irq || sidestream_irq |=> !(adc_irq && $past(adc_irq))
         && !(resampler_irq && $past(resampler_irq)) && !(sidestream_irq && $past(sidestream_irq));
   endproperty
   property p_adc_run;
      s_adc_wr |-> ##2 adc_left_run == ($past(bus.wdata[0], 2) && !$past(bus.wdata[3], 2))
         && adc_right_run == ($past(bus.wdata[0], 2) && !$past(bus.wdata[4], 2));
   endproperty
   a_port_on: assert property (p_port_on) else $error("port stays off");
   a_pins_idle: assert property (p_pins_idle) else $error("pins move while off");
   a_mclk_off: assert property (p_mclk_off) else $error("master clock not gated");
   a_mclk_norm: assert property (p_mclk_norm) else $error("master clock rate");
   a_mclk_high: assert property (p_mclk_high) else $error("master clock half rate");
   a_rs_period: assert property (p_rs_period) else $error("resampler spacing");
   a_sd_period: assert property (p_sd_period) else $error("sidestream spacing");
   a_irq_single: assert property (p_irq_single) else $error("interrupt too long");
   a_adc_run: assert property (p_adc_run) else $error("adc run state");
endmodule

bind asp_top asp_top_checker asp_top_checker_inst
(
   .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
   .high_input_clock_range(high_input_clock_range), .master_clock_out(master_clock_out),
   .bit_clock_out(bit_clock_out), .frame_clock_out(frame_clock_out),
   .serial_data_out(serial_data_out), .port_pins_active(port_pins_active),
   .adc_left_run(adc_left_run), .adc_right_run(adc_right_run), .adc_irq(adc_irq),
   .resampler_irq(resampler_irq), .sidestream_irq(sidestream_irq)
);

// >>> sim/asp_i2s_dac_model.sv
// Serial DAC model: measures the clocks and slot length it receives.
// Assumes it only listens; it never drives the shared port pins.
`timescale 1ns/100ps
module asp_i2s_dac_model
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic master_clock_out,
   input wire logic bit_clock_out,
   input wire logic frame_clock_out,
   input wire logic serial_data_out,
   output logic [15:0] mclk_period,
   output logic [15:0] bclk_period,
   output logic [15:0] slot_bits,
   output logic [15:0] rx_word
);
   logic [15:0] mcnt, bcnt, scnt;
   logic mclk_q, bclk_q, fclk_q, m_rise, b_rise, f_edge;
   assign m_rise = master_clock_out && !mclk_q;
   assign b_rise = bit_clock_out && !bclk_q;
   assign f_edge = frame_clock_out != fclk_q;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         {mclk_period, bclk_period, slot_bits, rx_word, mcnt, bcnt, scnt} <= '0;
      else
      begin
         mcnt <= m_rise ? 16'h0001 : mcnt + 16'h0001;
         bcnt <= b_rise ? 16'h0001 : bcnt + 16'h0001;
         // A rise on the frame edge belongs to the new slot
         scnt <= f_edge ? 16'(b_rise) : scnt + 16'(b_rise);
         if (m_rise)
            mclk_period <= mcnt;
         if (b_rise)
            {bclk_period, rx_word} <= {bcnt, rx_word[14:0], serial_data_out};
         if (f_edge)
            slot_bits <= scnt;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         {mclk_q, bclk_q, fclk_q} <= '0;
      else
         {mclk_q, bclk_q, fclk_q} <= {master_clock_out, bit_clock_out, frame_clock_out};
   end
endmodule

// >>> sim/tb_audio_sample_ports.sv
// Self-checking bench for asp_top with a listening serial DAC model.
// Assumes reads answer one cycle later and interrupts last one cycle.
`timescale 1ns/100ps
module tb_audio_sample_ports
   import asp_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   asp_bus_s bus = '0;
   logic high_input_clock_range = 1'b0;
   logic adc_half_speed = 1'b0;
   asp_pair_s dac_path = '0;
   asp_pair_s adc_raw = '0;
   asp_pair_s dac_mixed;
   logic [15:0] bus_rdata, mclk_period, bclk_period, slot_bits;
   logic master_clock_out, bit_clock_out, frame_clock_out, serial_data_out;
   logic port_pins_active, adc_left_run, adc_right_run;
   logic adc_irq, resampler_irq, sidestream_irq, rd_pend;
   logic [2:0] irqs;
   logic [15:0] exp_q[$];
   string name_q[$];
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   // Writable bits per register; the ADC and resampler sample registers have none
   logic [15:0] addr_tab[10] = '{ASP_ADDR_I2S_SETUP, ASP_ADDR_ADC_CTRL, ASP_ADDR_ADC_LEFT,
      ASP_ADDR_ADC_RIGHT, ASP_ADDR_RSMP_CTRL, ASP_ADDR_RSMP_LEFT, ASP_ADDR_RSMP_RIGHT,
      ASP_ADDR_SIDE_CTRL, ASP_ADDR_SIDE_LEFT, ASP_ADDR_SIDE_RIGHT};
   logic [15:0] mask_tab[10] = '{16'h000F, 16'h001F, 16'h0000, 16'h0000, 16'h1FFF,
      16'h0000, 16'h0000, 16'h1FFF, 16'hFFFF, 16'hFFFF};
   assign irqs = {sidestream_irq, resampler_irq, adc_irq};
   always #10 clk_sys = ~clk_sys;
   asp_top asp_top_inst
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
      .high_input_clock_range(high_input_clock_range), .adc_half_speed(adc_half_speed),
      .dac_path(dac_path), .adc_raw(adc_raw), .dac_mixed(dac_mixed),
      .master_clock_out(master_clock_out), .bit_clock_out(bit_clock_out),
      .frame_clock_out(frame_clock_out), .serial_data_out(serial_data_out),
      .port_pins_active(port_pins_active), .adc_left_run(adc_left_run),
      .adc_right_run(adc_right_run), .adc_irq(adc_irq), .resampler_irq(resampler_irq),
      .sidestream_irq(sidestream_irq)
   );
   asp_i2s_dac_model asp_i2s_dac_model_inst
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .master_clock_out(master_clock_out),
      .bit_clock_out(bit_clock_out), .frame_clock_out(frame_clock_out),
      .serial_data_out(serial_data_out), .mclk_period(mclk_period),
      .bclk_period(bclk_period), .slot_bits(slot_bits), .rx_word()
   );
   task automatic summarize();
      if (n_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
      checks_done++;
      if (got !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, e, got);
      end
   endtask
   task automatic wr(input logic w, input logic [15:0] a, input logic [15:0] d);
      bus = '{write: w, read: !w, addr: a, wdata: d};
      @(posedge clk_sys);
      #1 bus = '0;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input string what);
      exp_q.push_back(e);
      name_q.push_back(what);
      wr(1'b0, a, 16'h0000);
   endtask
   // Cycles between two pulses of one interrupt, 4096 when none comes
   task automatic irq_gap(input int k, output logic [15:0] n);
      n = 16'h0000;
      while (irqs[k] !== 1'b1 && n < 16'h1000)
      begin
         @(negedge clk_sys);
         n++;
      end
      n = 16'h0000;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (irqs[k] !== 1'b1 && n < 16'h1000);
      @(posedge clk_sys);
      #1;
   endtask
   always @(posedge clk_sys)
   begin
      rd_pend <= bus.read;
      cycles++;
      if (cycles == 60000)
      begin
         n_errors++;
         summarize();
      end
   end
   always @(negedge clk_sys)
      if (rd_pend === 1'b1)
         check(name_q.pop_front(), exp_q.pop_front(), bus_rdata);
   initial
   begin
      logic [15:0] n, v, e, f;
      v = 16'($urandom(28095));
      repeat (5) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      foreach (addr_tab[i]) rd(addr_tab[i], 16'h0000, "reset value");
      wr(1'b1, 16'hC045, 16'hFFFF);
      rd(16'hC045, 16'h0000, "unmapped");
      foreach (addr_tab[i])
      begin
         v = 16'($urandom);
         wr(1'b1, addr_tab[i], v);
         rd(addr_tab[i], v & mask_tab[i], "readback");
      end
      foreach (addr_tab[i]) if (i == 0 || i % 3 == 1) wr(1'b1, addr_tab[i], 16'h0000);
      for (int h = 0; h < 2; h++)
         for (int c = 0; c < 3; c++)
         begin
            high_input_clock_range = h[0];
            wr(1'b1, ASP_ADDR_I2S_SETUP, 16'(c));
            wr(1'b1, ASP_ADDR_I2S_SETUP, 16'(c) | 16'h000C);
            e = 16'(2 << h) * (16'h0008 >> c);
            repeat (130 * e) @(posedge clk_sys);
            #1;
            check("master clock period", 16'(2 << h), mclk_period);
            check("bit clock period", e, bclk_period);
            check("slot length", 16'h0020, slot_bits);
            wr(1'b1, ASP_ADDR_I2S_SETUP, 16'((c + 1) % 3) | 16'h000C);
            rd(ASP_ADDR_I2S_SETUP, 16'(c) | 16'h000C, "rate while on");
            wr(1'b1, ASP_ADDR_I2S_SETUP, 16'h0000);
         end
      adc_raw = {16'($urandom), 16'($urandom)};
      for (int k = 0; k < 8; k++)
      begin
         adc_half_speed = k[2];
         v = 16'h0001 | 16'(k % 4) << 1 | 16'(k % 2) << 3 | 16'(k / 6) << 4;
         wr(1'b1, ASP_ADDR_ADC_CTRL, v);
         irq_gap(0, n);
         irq_gap(0, n);
         check("adc period", 16'h0040 << (k % 4) << (k / 4), n);
         rd(ASP_ADDR_ADC_LEFT, v[3] ? 16'h0000 : adc_raw.left, "adc left");
         rd(ASP_ADDR_ADC_RIGHT, v[4] ? 16'h0000 : adc_raw.right, "adc right");
      end
      wr(1'b1, ASP_ADDR_ADC_CTRL, 16'h0000);
      irq_gap(0, n);
      check("adc stopped", 16'h1000, n);
      dac_path = {16'($urandom), 16'($urandom)};
      for (int i = 0; i < 2; i++)
      begin
         v = i ? 16'($urandom_range(40)) : 16'h0000;
         wr(1'b1, ASP_ADDR_RSMP_CTRL, v | 16'h1000);
         irq_gap(1, n);
         irq_gap(1, n);
         check("resampler period", (v + 16'h0001) << 1, n);
         rd(ASP_ADDR_RSMP_LEFT, dac_path.left, "resampler left");
         rd(ASP_ADDR_RSMP_RIGHT, dac_path.right, "resampler right");
      end
      check("mix idle", dac_path.left, dac_mixed.left);
      e = 16'($urandom);
      f = 16'($urandom);
      v = 16'($urandom_range(20));
      wr(1'b1, ASP_ADDR_SIDE_LEFT, e);
      wr(1'b1, ASP_ADDR_SIDE_RIGHT, f);
      wr(1'b1, ASP_ADDR_SIDE_CTRL, v | 16'h1000);
      irq_gap(2, n);
      irq_gap(2, n);
      check("sidestream period", (v + 16'h0001) << 1, n);
      check("mix left", dac_path.left + e, dac_mixed.left);
      check("mix right", dac_path.right + f, dac_mixed.right);
      summarize();
   end
endmodule
